// ==== src/dma_ptr_defs.vh ====
`ifndef DMA_PTR_DEFS_VH
`define DMA_PTR_DEFS_VH

// ==========================================================================
// Register byte offsets
`define OFS_CTRL 5'h00
`define OFS_SRC_START 5'h04
`define OFS_SRC_SIZE 5'h08
`define OFS_DST_START 5'h0c
`define OFS_DST_SIZE 5'h10
`define OFS_SRC_PTR 5'h14
`define OFS_SRC_CNT 5'h18
`define OFS_DST_PTR 5'h1c

// ==========================================================================
// Control register fields
`define CTRL_EN_BIT 0
`define CTRL_GO_BIT 1
`define CTRL_SRC_STEP_MODE_LO 4
`define CTRL_SRC_STEP_MODE_HI 5
`define CTRL_DST_STEP_MODE_LO 6
`define CTRL_DST_STEP_MODE_HI 7

// ==========================================================================
// Widths, step modes and reset values
`define SRC_PTR_W 22
`define DST_PTR_W 16
`define CNT_W 12
`define MODE_HOLD 2'h0
`define MODE_INC 2'h1
`define MODE_DEC 2'h2
`define MODE_HOLD2 2'h3
`define CNT_ONE 12'h001
`define BRESP_OKAY 2'h0
`define BRESP_SLVERR 2'h2

`endif

// ==== src/dma_step_unit.v ====
`include "dma_ptr_defs.vh"

// Steps one pointer and its counter after each transaction.
module dma_step_unit #(
  parameter PW = 16
) (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Control
  input wire load,
  input wire step,
  input wire [1:0] mode,
  input wire [PW-1:0] startAddr,
  input wire [`CNT_W-1:0] size,
  // State
  output reg [PW-1:0] pointer_reg,
  output reg [`CNT_W-1:0] counter_reg
);

  localparam [PW-1:0] ONE_PTR = {{(PW-1){1'b0}}, 1'b1};

  reg [PW-1:0] pointer_next;
  reg [`CNT_W-1:0] counter_next;

  always @* begin
    pointer_next = pointer_reg;
    counter_next = counter_reg;
    if (load) begin
      pointer_next = startAddr;
      counter_next = size;
    end else if (step) begin
      if (counter_reg != `CNT_ONE) begin
        counter_next = counter_reg - `CNT_ONE;
        case (mode)
          `MODE_INC: pointer_next = pointer_reg + ONE_PTR;
          `MODE_DEC: pointer_next = pointer_reg - ONE_PTR;
          default: pointer_next = pointer_reg;
        endcase
      end else begin
        counter_next = size;
        pointer_next = startAddr;
      end
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pointer_reg <= {PW{1'b0}};
      counter_reg <= {`CNT_W{1'b0}};
    end else begin
      pointer_reg <= pointer_next;
      counter_reg <= counter_next;
    end
  end

endmodule

// ==== src/dma_pointer_counter_control.v ====
`include "dma_ptr_defs.vh"

// What this block does
// - Enable rising edge loads pointers and counters.
// - Source counter decrements when not one.
// - Source pointer holds, increments or decrements.
// - Source reloads from start and size at one.
// - Destination counter decrements when not one.
// - Destination pointer holds, increments or decrements.
// - Destination reloads from start and size.
// - Transfers start by go bit or trigger.
// - Setting go starts, clearing go halts.
// - Trigger sets go while enabled; go shows message active.
// - Software go ignored while channel disabled.
// - Writing go while set changes nothing.
module dma_pointer_counter_control (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // AXI4-Lite write address
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Transaction engine
  input wire start_trigger,
  input wire transactionDone,
  output wire transferActive,
  output wire [`SRC_PTR_W-1:0] src_pointer,
  output wire [`DST_PTR_W-1:0] dst_pointer,
  output wire [`CNT_W-1:0] src_counter,
  output wire [`CNT_W-1:0] dst_counter
);

  // ========================================================================
  // Register state
  reg enable_reg;
  reg transfer_go_reg;
  reg [1:0] src_step_mode_reg;
  reg [1:0] dst_step_mode_reg;
  reg [`SRC_PTR_W-1:0] src_start_addr_reg;
  reg [`DST_PTR_W-1:0] dst_start_addr_reg;
  reg [`CNT_W-1:0] src_size_reg;
  reg [`CNT_W-1:0] dst_size_reg;
  reg awHeld_reg;
  reg wHeld_reg;
  reg [31:0] awAddr_reg;
  reg [31:0] wData_reg;
  reg [3:0] wStrb_reg;

  reg enable_next;
  reg transfer_go_next;
  reg [31:0] rdata_next;
  reg rdataOk;

  wire [`SRC_PTR_W-1:0] srcPtr;
  wire [`DST_PTR_W-1:0] dstPtr;
  wire [`CNT_W-1:0] srcCnt;
  wire [`CNT_W-1:0] dstCnt;

  // ========================================================================
  // Write channel: address and data are caught in either order, then one
  // response. Both ready lines stay low until the response is taken, which
  // keeps one write in flight.
  assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
  assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;

  wire awFire = s_axi_awvalid && s_axi_awready;
  wire wFire = s_axi_wvalid && s_axi_wready;
  wire haveAw = awHeld_reg || awFire;
  wire haveW = wHeld_reg || wFire;
  wire [31:0] wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
  wire [31:0] wrData = wHeld_reg ? wData_reg : s_axi_wdata;
  wire [3:0] wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
  wire doWrite = haveAw && haveW && !s_axi_bvalid;
  // Only the five writable registers accept a write; the read-only status
  // registers and anything unaligned answer with a slave error.
  wire wrMapped = wrAddr[31:5] == 27'h0 && wrAddr[1:0] == 2'h0 &&
                  wrAddr[4:0] <= `OFS_DST_SIZE;
  wire wrCtrl = doWrite && wrMapped && wrAddr[4:0] == `OFS_CTRL &&
                wrStrb[0];

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= 32'h0;
      wData_reg <= 32'h0;
      wStrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BRESP_OKAY;
    end else begin
      if (doWrite) begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `BRESP_OKAY : `BRESP_SLVERR;
      end else begin
        if (awFire) begin
          awHeld_reg <= 1'b1;
          awAddr_reg <= s_axi_awaddr;
        end
        if (wFire) begin
          wHeld_reg <= 1'b1;
          wData_reg <= s_axi_wdata;
          wStrb_reg <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ========================================================================
  // Configuration registers, written a byte lane at a time.
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      src_step_mode_reg <= `MODE_HOLD;
      dst_step_mode_reg <= `MODE_HOLD;
      src_start_addr_reg <= {`SRC_PTR_W{1'b0}};
      dst_start_addr_reg <= {`DST_PTR_W{1'b0}};
      src_size_reg <= {`CNT_W{1'b0}};
      dst_size_reg <= {`CNT_W{1'b0}};
    end else if (doWrite && wrMapped) begin
      case (wrAddr[4:0])
        `OFS_CTRL: begin
          if (wrStrb[0]) begin
            src_step_mode_reg <= wrData[`CTRL_SRC_STEP_MODE_HI:`CTRL_SRC_STEP_MODE_LO];
            dst_step_mode_reg <= wrData[`CTRL_DST_STEP_MODE_HI:`CTRL_DST_STEP_MODE_LO];
          end
        end
        `OFS_SRC_START: begin
          if (wrStrb[0]) src_start_addr_reg[7:0] <= wrData[7:0];
          if (wrStrb[1]) src_start_addr_reg[15:8] <= wrData[15:8];
          if (wrStrb[2]) src_start_addr_reg[21:16] <= wrData[21:16];
        end
        `OFS_SRC_SIZE: begin
          if (wrStrb[0]) src_size_reg[7:0] <= wrData[7:0];
          if (wrStrb[1]) src_size_reg[11:8] <= wrData[11:8];
        end
        `OFS_DST_START: begin
          if (wrStrb[0]) dst_start_addr_reg[7:0] <= wrData[7:0];
          if (wrStrb[1]) dst_start_addr_reg[15:8] <= wrData[15:8];
        end
        `OFS_DST_SIZE: begin
          if (wrStrb[0]) dst_size_reg[7:0] <= wrData[7:0];
          if (wrStrb[1]) dst_size_reg[11:8] <= wrData[11:8];
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================================
  // Enable and go control.
  wire swEnable = wrData[`CTRL_EN_BIT];
  wire swGo = wrData[`CTRL_GO_BIT];
  // Only a change of enable from 0 to 1 reloads; rewriting enable while it
  // is set leaves a running message where it is.
  wire enableRise = enable_next && !enable_reg;
  wire loadPtrs = enableRise;

  always @* begin
    enable_next = enable_reg;
    transfer_go_next = transfer_go_reg;
    if (wrCtrl) begin
      enable_next = swEnable;
      if (!swGo) begin
        transfer_go_next = 1'b0;
      // Needs enable; set-while-set is a no-op.
      end else if (swEnable && !transfer_go_reg) begin
        transfer_go_next = 1'b1;
      end
    end
    // Trigger sets go while enabled, and wins over a go clear in the same cycle.
    if (start_trigger && enable_next) begin
      transfer_go_next = 1'b1;
    end
    if (!enable_next) begin
      transfer_go_next = 1'b0;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= 1'b0;
      transfer_go_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      transfer_go_reg <= transfer_go_next;
    end
  end

  assign transferActive = transfer_go_reg;

  // A done strobe only steps while a message runs, so a stray strobe after
  // a halt cannot disturb the pointers software will read back.
  wire stepNow = transactionDone && transfer_go_reg && enable_reg;

  // ========================================================================
  // Pointer and counter sequencing.
  // Enable loads source.
  dma_step_unit #(.PW(`SRC_PTR_W)) srcUnit (
    .clock(clock),
    .rst_n(rst_n),
    .load(loadPtrs),
    .step(stepNow),
    .mode(src_step_mode_reg),
    .startAddr(src_start_addr_reg),
    .size(src_size_reg),
    .pointer_reg(srcPtr),
    .counter_reg(srcCnt)
  );

  dma_step_unit #(.PW(`DST_PTR_W)) dstUnit (
    .clock(clock),
    .rst_n(rst_n),
    .load(loadPtrs),
    .step(stepNow),
    .mode(dst_step_mode_reg),
    .startAddr(dst_start_addr_reg),
    .size(dst_size_reg),
    .pointer_reg(dstPtr),
    .counter_reg(dstCnt)
  );

  assign src_pointer = srcPtr;
  assign dst_pointer = dstPtr;
  assign src_counter = srcCnt;
  assign dst_counter = dstCnt;

  // ========================================================================
  // Read channel: one cycle from address to data.
  // Map: control at 0x00, source start and size at 0x04 and 0x08,
  // destination start and size at 0x0c and 0x10, then the read-only source
  // pointer, source count and destination pointer at 0x14 to 0x1c. The
  // destination count has no slot left in the 32-byte window; the engine
  // sees it on its own port.
  assign s_axi_arready = !s_axi_rvalid;

  always @* begin
    rdata_next = 32'h0;
    rdataOk = s_axi_araddr[31:5] == 27'h0 && s_axi_araddr[1:0] == 2'h0;
    case (s_axi_araddr[4:0])
      `OFS_CTRL: begin
        rdata_next[`CTRL_EN_BIT] = enable_reg;
        rdata_next[`CTRL_GO_BIT] = transfer_go_reg;
        rdata_next[`CTRL_SRC_STEP_MODE_HI:`CTRL_SRC_STEP_MODE_LO] = src_step_mode_reg;
        rdata_next[`CTRL_DST_STEP_MODE_HI:`CTRL_DST_STEP_MODE_LO] = dst_step_mode_reg;
      end
      `OFS_SRC_START: rdata_next[`SRC_PTR_W-1:0] = src_start_addr_reg;
      `OFS_SRC_SIZE: rdata_next[`CNT_W-1:0] = src_size_reg;
      `OFS_DST_START: rdata_next[`DST_PTR_W-1:0] = dst_start_addr_reg;
      `OFS_DST_SIZE: rdata_next[`CNT_W-1:0] = dst_size_reg;
      `OFS_SRC_PTR: rdata_next[`SRC_PTR_W-1:0] = srcPtr;
      `OFS_SRC_CNT: rdata_next[`CNT_W-1:0] = srcCnt;
      `OFS_DST_PTR: rdata_next[`DST_PTR_W-1:0] = dstPtr;
      default: rdataOk = 1'b0;
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `BRESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdataOk ? rdata_next : 32'h0;
      s_axi_rresp <= rdataOk ? `BRESP_OKAY : `BRESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// ==== sim/dma_bus_model.sv ====
module dma_bus_model (
  // Clock and reset
  input wire clock,
  input wire rst_n,
  // Burst request
  input wire kick,
  input wire [7:0] want,
  // Engine status
  output logic transactionDone,
  output logic busy
);
  timeunit 1ns;
  timeprecision 100ps;
  int n;
  // =====
  // Engine
  // A gap of at least one idle cycle keeps two pulses from merging.
  initial begin
    transactionDone = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clock);
      if (kick && rst_n) begin
        busy <= 1'b1;
        n = want;
        while (n > 0) begin
          repeat (1 + $urandom % 3) @(posedge clock);
          transactionDone <= 1'b1;
          @(posedge clock);
          transactionDone <= 1'b0;
          n--;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// ==== sim/dma_pcc_checker.sv ====
`include "dma_ptr_defs.vh"
module dma_pcc_checker (
  // Watched ports
  input wire clock,
  input wire rst_n,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire start_trigger,
  input wire transactionDone,
  input wire transferActive,
  input wire [`SRC_PTR_W-1:0] src_pointer,
  input wire [`DST_PTR_W-1:0] dst_pointer,
  input wire [`CNT_W-1:0] src_counter,
  input wire [`CNT_W-1:0] dst_counter
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // =====
  // Steps
  sequence srcStep;
    transactionDone && transferActive && src_counter != `CNT_ONE;
  endsequence
  sequence dstStep;
    transactionDone && transferActive && dst_counter != `CNT_ONE;
  endsequence
  chk_src_count_dec:
  assert property (srcStep |=> src_counter == $past(src_counter) - 12'h001)
    else $error("source count did not step down");
  chk_dst_count_dec:
  assert property (dstStep |=> dst_counter == $past(dst_counter) - 12'h001)
    else $error("destination count did not step down");
  chk_src_ptr_step:
  assert property (srcStep |=> src_pointer == $past(src_pointer) ||
    src_pointer == $past(src_pointer) + 22'h1 ||
    src_pointer == $past(src_pointer) - 22'h1)
    else $error("source pointer moved by more than one");
  chk_dst_ptr_step:
  assert property (dstStep |=> dst_pointer == $past(dst_pointer) ||
    dst_pointer == $past(dst_pointer) + 16'h1 ||
    dst_pointer == $past(dst_pointer) - 16'h1)
    else $error("destination pointer moved by more than one");
  chk_halt_hold:
  assert property (transactionDone && !transferActive |=> $stable(src_counter)
    && $stable(dst_counter) || $rose(s_axi_bvalid))
    else $error("counters moved while halted");
  chk_go_rise:
  assert property ($rose(transferActive) |-> $rose(s_axi_bvalid) ||
    $past(start_trigger) || $past(start_trigger, 2))
    else $error("go set without write or trigger");
  chk_go_fall:
  assert property ($fell(transferActive) |-> $rose(s_axi_bvalid))
    else $error("go cleared without a write");
  chk_read_answer:
  assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule
bind dma_pointer_counter_control dma_pcc_checker chk (.clock(clock),
  .rst_n(rst_n), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .start_trigger(start_trigger), .transactionDone(transactionDone),
  .transferActive(transferActive), .src_pointer(src_pointer),
  .dst_pointer(dst_pointer), .src_counter(src_counter),
  .dst_counter(dst_counter));

// ==== sim/test_dma_pointer_counter_control.sv ====
`include "dma_ptr_defs.vh"
module test_dma_pointer_counter_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_n, awvalid, wvalid, bready, arvalid, rready, trig, kick;
  logic [31:0] awaddr, wdata, araddr;
  logic [7:0] want;
  wire awready, wready, bvalid, arready, rvalid, done, active, busy;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [21:0] sPtr;
  wire [15:0] dPtr;
  wire [11:0] sCnt, dCnt;
  int mismatches, check_count;
  logic [61:0] notes[$];
  logic [21:0] sp, sa;
  logic [15:0] dp, da;
  logic [11:0] sc, dc, ss, ds;
  logic [1:0] sm, dm;
  dma_pointer_counter_control uut (.clock(clock), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .start_trigger(trig),
    .transactionDone(done), .transferActive(active), .src_pointer(sPtr),
    .dst_pointer(dPtr), .src_counter(sCnt), .dst_counter(dCnt));
  dma_bus_model peer (.clock(clock), .rst_n(rst_n), .kick(kick),
    .want(want), .transactionDone(done), .busy(busy));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // =====
  // Tasks
  task automatic chk(input string n, input logic [63:0] s, e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Handshakes are judged at the falling edge, where nothing is moving.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic ha, hw, fin;
    fin = 0;
    awaddr <= {27'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!fin) begin
      @(negedge clock);
      ha = awvalid & awready;
      hw = wvalid & wready;
      fin = bvalid & bready;
      if (fin) chk("bresp", bresp, `BRESP_OKAY);
      @(posedge clock);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
  endtask
  // The response ready lines stay high between transfers, so that a call
  // straight after another never drives them twice in one time step.
  task automatic rd(input logic [31:0] a, input logic [1:0] r,
                    input logic [31:0] d);
    logic ha, fin;
    fin = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!fin) begin
      @(negedge clock);
      ha = arvalid & arready;
      fin = rvalid & rready;
      if (fin) chk("read", {rresp, rdata}, {r, d});
      @(posedge clock);
      if (ha) arvalid <= 1'b0;
    end
  endtask
  function automatic logic [21:0] mv(input logic [21:0] p, logic [1:0] m);
    return (m == 2'h1) ? p + 22'h1 : (m == 2'h2) ? p - 22'h1 : p;
  endfunction
  task automatic step;
    if (sc != 12'h1) {sc, sp} = {sc - 12'h1, mv(sp, sm)};
    else {sc, sp} = {ss, sa};
    if (dc != 12'h1) {dc, dp} = {dc - 12'h1, 16'(mv({6'h0, dp}, dm))};
    else {dc, dp} = {ds, da};
  endtask
  task automatic run(input int n, input bit note);
    repeat (n) if (note) begin
      step();
      notes.push_back({sp, sc, dp, dc});
    end
    want <= 8'(n);
    kick <= 1'b1;
    @(posedge clock);
    kick <= 1'b0;
    @(posedge clock);
    while (busy === 1'b1) @(posedge clock);
    @(posedge clock);
  endtask
  always @(posedge clock) if (done === 1'b1 && active === 1'b1) begin
    #1;
    if (notes.size() == 0) chk("extra", 64'h1, 64'h0);
    else chk("step", {sPtr, sCnt, dPtr, dCnt}, notes.pop_front());
  end
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
  initial begin
    {mismatches, check_count, awaddr, wdata, araddr, want} = 0;
    {awvalid, wvalid, bready, arvalid, rready, trig, kick, rst_n} = 0;
    void'($urandom(32'h519437ea));
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(32'h40, `BRESP_SLVERR, 32'h0);
    wr(`OFS_CTRL, 32'h2);
    chk("idle", active, 0);
    for (int i = 0; i < 4; i++) begin
      sa = 22'($urandom);
      da = 16'($urandom);
      ss = 12'(1 + $urandom % 4);
      ds = 12'(1 + $urandom % 5);
      {sm, dm} = {2'(i), 2'(3 - i)};
      wr(`OFS_SRC_START, {10'h0, sa});
      wr(`OFS_SRC_SIZE, {20'h0, ss});
      wr(`OFS_DST_START, {16'h0, da});
      wr(`OFS_DST_SIZE, {20'h0, ds});
      wr(`OFS_CTRL, {24'h0, dm, sm, 4'h0});
      wr(`OFS_CTRL, {24'h0, dm, sm, 4'h1});
      {sp, sc, dp, dc} = {sa, ss, da, ds};
      chk("load", {sPtr, sCnt, dPtr, dCnt}, {sp, sc, dp, dc});
      rd(`OFS_SRC_PTR, `BRESP_OKAY, {10'h0, sa});
      rd(`OFS_DST_PTR, `BRESP_OKAY, {16'h0, da});
      wr(`OFS_CTRL, {24'h0, dm, sm, 4'h3});
      chk("go", active, 1);
      run(7, 1);
      wr(`OFS_CTRL, {24'h0, dm, sm, 4'h3});
      chk("again", {sPtr, sCnt, dPtr, dCnt}, {sp, sc, dp, dc});
      run(3, 1);
      wr(`OFS_CTRL, {24'h0, dm, sm, 4'h1});
      chk("stop", active, 0);
      run(2, 0);
      chk("halt", {sPtr, sCnt, dPtr, dCnt}, {sp, sc, dp, dc});
      rd(`OFS_SRC_CNT, `BRESP_OKAY, {20'h0, sc});
      trig <= 1'b1;
      @(posedge clock);
      trig <= 1'b0;
      repeat (3) @(posedge clock);
      chk("trig", active, 1);
      rd(`OFS_CTRL, `BRESP_OKAY, {24'h0, dm, sm, 4'h3});
      run(4, 1);
    end
    chk("left", notes.size(), 0);
    end_of_test();
  end
endmodule
